// ### design/mdst_top.sv
// Management serial controller: status, fault, presence, link and event logic
// ------------------------------------------------------------------
// Summary of operation
// RL1 - Control field 28:24 reads 1: two command channels exist.
// RL2 - Preamble disable 0 sends 32-bit preamble; 1 omits it.
// RL3 - With detection on, pin readback mismatch sets fault and resets engine.
// RL4 - Writing 1 to the fault flag clears it.
// RL5 - Fault detection only works while the detect enable is 1.
// RL6 - Serial clock equals system clock divided by divider plus one.
// RL7 - Divider zero stops the serial clock.
// RL8 - Presence bit per address follows acknowledge of the latest access.
// RL9 - Both command and polling accesses update presence bits.
// RL10 - Writing 1 clears a presence bit, 0 leaves it.
// RL11 - Status register reads set link bit on link and ack, else clear.
// RL12 - Software writes to link bits are ignored.
// RL13 - Raw link change bit per channel sets on monitored link change; W1C.
// RL14 - Masked link change sets only with that channel link irq enable; W1C.
// RL15 - Raw command done bit sets when that channel access finishes; W1C.
// RL16 - Masked command done sets only when mask bit is 1; W1C.
// RL17 - Mask set writes 1 to enable; mask 0 disables completion irq.
// RL18 - Disabling mid-frame finishes the frame, then halts and shows idle.
// RL19 - Start bit set only while enabled; self-clears; register locked meanwhile.
// RL20 - Each channel has link irq enable and 5-bit monitored address.
// RL21 - Link source select reads 0: engine is the only source.
// RL22 - Link irq is OR of masked link bits; user irq OR of masked done.
// RL23 - After reset all flags, masks, presence, link read zero; engine idle.
// ------------------------------------------------------------------
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`include "mdst_regs.svh"

module mdst_top
  import mdst_pkg::*;
(
  input  wire logic        sys_clk,    // 100 MHz system clock
  input  wire logic        sys_rst,    // Async reset, active high
  input  wire logic        wb_cyc_i,   // Wishbone cycle
  input  wire logic        wb_stb_i,   // Wishbone strobe
  input  wire logic        wb_we_i,    // Wishbone write enable
  input  wire logic [7:0]  wb_adr_i,   // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,   // Wishbone byte selects
  input  wire logic [31:0] wb_dat_i,   // Wishbone write data
  output logic      [31:0] wb_dat_o,   // Wishbone read data
  output logic             wb_ack_o,   // Wishbone acknowledge
  output logic             mgmt_serial_clock, // Serial management clock
  output logic             mdio_o,     // Data pin drive value
  output logic             mdio_oe,    // Data pin output enable
  input  wire logic        mdio_i,     // Data pin level
  output logic             link_irq,   // Link change interrupt
  output logic             user_irq    // Command done interrupt
);

  // ------------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------------
  logic        req;
  logic        wr;
  logic [31:0] wmask;
  logic [31:0] wd;
  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr    = req && wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wd    = wb_dat_i & wmask;

  logic        enable_reg;
  logic        pre_dis_reg;
  logic        fault_reg;
  logic        fault_en_reg;
  logic [15:0] div_reg;
  logic [31:0] presence_reg;
  logic [31:0] link_reg;
  logic [31:0] link_next;
  logic [1:0]  lc_raw_reg;
  logic [1:0]  lc_msk_reg;
  logic [1:0]  cd_raw_reg;
  logic [1:0]  cd_msk_reg;
  logic [1:0]  mask_reg;
  logic [31:0] cmd_reg [2];
  logic [4:0]  mon_addr_reg [2];
  logic [1:0]  link_en_reg;
  mdst_state_t state_reg;

  logic        wr_ctl;
  logic        fault_set;
  logic        frame_end;
  logic [1:0]  cd_set;
  logic [1:0]  lc_set;
  assign wr_ctl = wr && wb_adr_i == `MDST_OFF_CONTROL;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  logic [31:0] rdata;
  always_comb
  begin
    rdata = 32'h0000_0000;
    case (wb_adr_i)
      `MDST_OFF_CONTROL:  rdata = {state_reg == MDST_IDLE, enable_reg, 1'b0,
                                   `MDST_TOP_CHANNEL, 3'h0, pre_dis_reg, fault_reg, // RL1
                                   fault_en_reg, 2'h0, div_reg};
      `MDST_OFF_PRESENCE: rdata = presence_reg;
      `MDST_OFF_LINK:     rdata = link_reg;
      `MDST_OFF_LC_RAW:   rdata = {30'h0, lc_raw_reg};
      `MDST_OFF_LC_MSK:   rdata = {30'h0, lc_msk_reg};
      `MDST_OFF_CD_RAW:   rdata = {30'h0, cd_raw_reg};
      `MDST_OFF_CD_MSK:   rdata = {30'h0, cd_msk_reg};
      `MDST_OFF_MASK_SET: rdata = {30'h0, mask_reg};
      `MDST_OFF_MASK_CLR: rdata = {30'h0, mask_reg};
      `MDST_OFF_CMD0:     rdata = cmd_reg[0];
      `MDST_OFF_CMD1:     rdata = cmd_reg[1];
      `MDST_OFF_SEL0:     rdata = {25'h0, link_en_reg[0], 1'b0, mon_addr_reg[0]}; // RL21
      `MDST_OFF_SEL1:     rdata = {25'h0, link_en_reg[1], 1'b0, mon_addr_reg[1]};
      default:            rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      wb_dat_o <= 32'h0000_0000;
    else if (req && !wb_we_i)
      wb_dat_o <= rdata;
  end

  // ------------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      enable_reg   <= 1'b0;
      pre_dis_reg  <= 1'b0;
      fault_en_reg <= 1'b0;
      div_reg      <= `MDST_RST_DIV;
    end
    else if (wr_ctl)
    begin
      if (wb_sel_i[3])
        enable_reg <= wb_dat_i[`MDST_CTL_ENABLE];
      if (wb_sel_i[2])
      begin
        pre_dis_reg  <= wb_dat_i[`MDST_CTL_PRE_DIS];
        fault_en_reg <= wb_dat_i[`MDST_CTL_FAULT_EN];
      end
      div_reg <= (div_reg & ~wmask[15:0]) | wd[15:0];
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      fault_reg <= 1'b0;
    else
      fault_reg <= (fault_reg & ~(wr_ctl & wd[`MDST_CTL_FAULT])) | fault_set; // RL4
  end

  // ------------------------------------------------------------------
  // Serial clock divider
  // ------------------------------------------------------------------
  logic [15:0] div_cnt;
  logic [15:0] half;
  logic        bit_end;
  assign half    = 16'((17'(div_reg) + 17'h1) >> 1);
  assign bit_end = div_reg != 16'h0000 && div_cnt == div_reg;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_cnt           <= 16'h0000;
      mgmt_serial_clock <= 1'b0;
    end
    else if (div_reg == 16'h0000)
    begin
      div_cnt           <= 16'h0000;
      mgmt_serial_clock <= 1'b0; // RL7
    end
    else
    begin
      div_cnt           <= bit_end ? 16'h0000 : div_cnt + 16'h0001; // RL6
      mgmt_serial_clock <= div_cnt >= half;
    end
  end

  // ------------------------------------------------------------------
  // Frame engine
  // ------------------------------------------------------------------
  logic [63:0] frame_reg;
  logic [5:0]  idx_reg;
  logic        cur_wr;
  logic [4:0]  cur_phy;
  logic [4:0]  cur_rega;
  mdst_src_t   cur_src;
  logic        poll_ch;
  logic        ack_reg;
  logic [15:0] rd_reg;
  logic        drive;
  logic        out_bit;
  logic        start;
  logic [1:0]  go;
  assign go      = {cmd_reg[1][`MDST_CMD_GO], cmd_reg[0][`MDST_CMD_GO]};
  assign drive   = state_reg == MDST_FRAME && (cur_wr || idx_reg < `MDST_TA_BIT - 6'h1);
  assign out_bit = frame_reg[6'h3f - idx_reg];
  assign start   = state_reg == MDST_IDLE && enable_reg && bit_end; // RL18
  assign fault_set = fault_en_reg && bit_end && drive && mdio_i != out_bit; // RL3 RL5
  assign frame_end = state_reg == MDST_FRAME && bit_end && !fault_set &&
                     idx_reg == `MDST_LAST_BIT;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= MDST_IDLE; // RL23
      frame_reg <= 64'h0;
      idx_reg   <= 6'h00;
      cur_wr    <= 1'b0;
      cur_phy   <= 5'h00;
      cur_rega  <= 5'h00;
      cur_src   <= MDST_SRC_POLL;
      poll_ch   <= 1'b0;
    end
    else
    begin
      case (state_reg)
        MDST_IDLE:
        begin
          if (start)
          begin
            logic [31:0] c;
            c = go[0] ? cmd_reg[0] : cmd_reg[1];
            if (go != 2'b00)
            begin
              cur_src  <= go[0] ? MDST_SRC_CH0 : MDST_SRC_CH1;
              cur_wr   <= c[`MDST_CMD_WRITE];
              cur_phy  <= c[20:16];
              cur_rega <= c[25:21];
              frame_reg <= {32'hffff_ffff, 2'b01, c[`MDST_CMD_WRITE] ? 2'b01 : 2'b10,
                            c[20:16], c[25:21], 2'b10, c[15:0]};
            end
            else
            begin
              // Idle time polls the two monitored addresses in turn
              cur_src  <= MDST_SRC_POLL;
              cur_wr   <= 1'b0;
              cur_phy  <= mon_addr_reg[poll_ch];
              cur_rega <= `MDST_STATUS_REG;
              poll_ch  <= !poll_ch;
              frame_reg <= {32'hffff_ffff, 4'b0110, mon_addr_reg[poll_ch],
                            `MDST_STATUS_REG, 18'h3ffff};
            end
            idx_reg   <= pre_dis_reg ? `MDST_PRE_BITS : 6'h00; // RL2
            state_reg <= MDST_FRAME;
          end
        end
        MDST_FRAME:
        begin
          if (fault_set)
            state_reg <= MDST_IDLE; // RL3
          else if (bit_end)
          begin
            idx_reg <= idx_reg + 6'h01;
            if (idx_reg == `MDST_LAST_BIT)
              state_reg <= MDST_IDLE;
          end
        end
        default: state_reg <= MDST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ack_reg <= 1'b0;
      rd_reg  <= 16'h0000;
    end
    else if (state_reg == MDST_FRAME && bit_end)
    begin
      if (idx_reg == `MDST_TA_BIT)
        ack_reg <= cur_wr || !mdio_i;
      if (idx_reg >= `MDST_DATA_BIT)
        rd_reg <= {rd_reg[14:0], mdio_i};
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mdio_o  <= 1'b1;
      mdio_oe <= 1'b0;
    end
    else
    begin
      mdio_o  <= drive ? out_bit : 1'b1;
      mdio_oe <= drive;
    end
  end

  // ------------------------------------------------------------------
  // Presence and link tracking
  // ------------------------------------------------------------------
  logic [15:0] rd_full;
  logic        link_upd;
  assign rd_full  = {rd_reg[14:0], mdio_i};
  assign link_upd = frame_end && !cur_wr && cur_rega == `MDST_STATUS_REG;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      presence_reg <= 32'h0000_0000;
    else
    begin
      logic [31:0] p;
      p = presence_reg;
      if (wr && wb_adr_i == `MDST_OFF_PRESENCE)
        p = p & ~wd; // RL10
      if (frame_end)
        p[cur_phy] = ack_reg; // RL8 RL9
      presence_reg <= p;
    end
  end

  always_comb
  begin
    link_next = link_reg;
    if (link_upd)
      link_next[cur_phy] = ack_reg && rd_full[`MDST_STATUS_LINK]; // RL11
  end

  // Bus writes never reach the link bits
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      link_reg <= 32'h0000_0000;
    else
      link_reg <= link_next; // RL12
  end

  // ------------------------------------------------------------------
  // Command channels and monitor selects
  // ------------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chan
    logic done;
    logic wr_cmd;
    logic wr_sel;
    assign done   = frame_end && cur_src == mdst_src_t'(ch);
    assign wr_cmd = wr && wb_adr_i == (ch == 0 ? `MDST_OFF_CMD0 : `MDST_OFF_CMD1);
    assign wr_sel = wr && wb_adr_i == (ch == 0 ? `MDST_OFF_SEL0 : `MDST_OFF_SEL1);
    assign cd_set[ch] = done; // RL15
    assign lc_set[ch] = link_next[mon_addr_reg[ch]] != link_reg[mon_addr_reg[ch]]; // RL13

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
      if (sys_rst)
        cmd_reg[ch] <= 32'h0000_0000;
      else if (done)
        cmd_reg[ch] <= {1'b0, cmd_reg[ch][`MDST_CMD_WRITE], ack_reg, 3'h0,
                        cmd_reg[ch][25:16], cmd_reg[ch][`MDST_CMD_WRITE] ?
                        cmd_reg[ch][15:0] : rd_full}; // RL19
      else if (wr_cmd && !cmd_reg[ch][`MDST_CMD_GO]) // RL19
      begin
        logic [31:0] n;
        n = (cmd_reg[ch] & ~wmask) | wd;
        n[`MDST_CMD_GO] = wd[`MDST_CMD_GO] && enable_reg; // RL19
        n[28:26] = 3'h0;
        cmd_reg[ch] <= n;
      end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        link_en_reg[ch]  <= 1'b0;
        mon_addr_reg[ch] <= 5'h00;
      end
      else if (wr_sel && wb_sel_i[0])
      begin
        link_en_reg[ch]  <= wb_dat_i[`MDST_SEL_LINK_EN]; // RL20
        mon_addr_reg[ch] <= wb_dat_i[4:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Events and interrupt outputs
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lc_raw_reg <= 2'b00;
      lc_msk_reg <= 2'b00;
      cd_raw_reg <= 2'b00;
      cd_msk_reg <= 2'b00;
      mask_reg   <= 2'b00;
    end
    else
    begin
      lc_raw_reg <= (lc_raw_reg & ~(wr && wb_adr_i == `MDST_OFF_LC_RAW ? wd[1:0] : 2'b00))
                    | lc_set; // RL13
      lc_msk_reg <= (lc_msk_reg & ~(wr && wb_adr_i == `MDST_OFF_LC_MSK ? wd[1:0] : 2'b00))
                    | (lc_set & link_en_reg); // RL14
      cd_raw_reg <= (cd_raw_reg & ~(wr && wb_adr_i == `MDST_OFF_CD_RAW ? wd[1:0] : 2'b00))
                    | cd_set; // RL15
      cd_msk_reg <= (cd_msk_reg & ~(wr && wb_adr_i == `MDST_OFF_CD_MSK ? wd[1:0] : 2'b00))
                    | (cd_set & mask_reg); // RL16
      mask_reg   <= (mask_reg | (wr && wb_adr_i == `MDST_OFF_MASK_SET ? wd[1:0] : 2'b00))
                    & ~(wr && wb_adr_i == `MDST_OFF_MASK_CLR ? wd[1:0] : 2'b00); // RL17
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      link_irq <= 1'b0;
      user_irq <= 1'b0;
    end
    else
    begin
      link_irq <= |lc_msk_reg; // RL22
      user_irq <= |cd_msk_reg; // RL22
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  property p_top_chan;
    @(posedge sys_clk) disable iff (sys_rst)
    req && !wb_we_i && wb_adr_i == `MDST_OFF_CONTROL |=> wb_dat_o[28:24] == 5'h01;
  endproperty
  a_top_chan: assert property (p_top_chan) else $error("channel count wrong"); // RL1

  property p_preamble;
    @(posedge sys_clk) disable iff (sys_rst)
    start && pre_dis_reg |=> idx_reg == 6'h20;
  endproperty
  a_preamble: assert property (p_preamble) else $error("preamble not skipped"); // RL2

  property p_fault_reset;
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(fault_reg) |-> state_reg == MDST_IDLE && $past(fault_en_reg);
  endproperty
  a_fault_reset: assert property (p_fault_reset) else $error("fault handling wrong"); // RL3

  property p_clk_stop;
    @(posedge sys_clk) disable iff (sys_rst)
    div_reg == 16'h0000 [*2] |-> !mgmt_serial_clock;
  endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("clock runs at divider 0"); // RL7

  property p_link_ro;
    @(posedge sys_clk) disable iff (sys_rst)
    wr && wb_adr_i == `MDST_OFF_LINK && !link_upd |=> $stable(link_reg);
  endproperty
  a_link_ro: assert property (p_link_ro) else $error("link bits written"); // RL12

  property p_go_lock;
    @(posedge sys_clk) disable iff (sys_rst)
    go[0] && !(frame_end && cur_src == MDST_SRC_CH0) |=> $stable(cmd_reg[0]);
  endproperty
  a_go_lock: assert property (p_go_lock) else $error("command changed while busy"); // RL19

  property p_cd_masked;
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(cd_msk_reg[0]) |-> $past(mask_reg[0]) && cd_raw_reg[0];
  endproperty
  a_cd_masked: assert property (p_cd_masked) else $error("masked done without mask"); // RL16

  property p_start_en;
    @(posedge sys_clk) disable iff (sys_rst)
    state_reg == MDST_IDLE ##1 state_reg == MDST_FRAME |-> $past(enable_reg);
  endproperty
  a_start_en: assert property (p_start_en) else $error("frame started disabled"); // RL18

  property p_irq;
    @(posedge sys_clk) disable iff (sys_rst)
    lc_msk_reg != 2'b00 |=> link_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("link irq missing"); // RL22

  c_user_done: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(cd_raw_reg[0]));
  c_link_chg: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(lc_msk_reg[1]));
  c_fault: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(fault_reg));

endmodule : mdst_top

// ### design/mdst_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef MDST_REGS_SVH
`define MDST_REGS_SVH
`define MDST_OFF_CONTROL   8'h04
`define MDST_OFF_PRESENCE  8'h08
`define MDST_OFF_LINK      8'h0c
`define MDST_OFF_LC_RAW    8'h10
`define MDST_OFF_LC_MSK    8'h14
`define MDST_OFF_CD_RAW    8'h20
`define MDST_OFF_CD_MSK    8'h24
`define MDST_OFF_MASK_SET  8'h28
`define MDST_OFF_MASK_CLR  8'h2c
`define MDST_OFF_CMD0      8'h80
`define MDST_OFF_SEL0      8'h84
`define MDST_OFF_CMD1      8'h88
`define MDST_OFF_SEL1      8'h8c
`define MDST_CTL_IDLE      31
`define MDST_CTL_ENABLE    30
`define MDST_CTL_PRE_DIS   20
`define MDST_CTL_FAULT     19
`define MDST_CTL_FAULT_EN  18
`define MDST_CMD_GO        31
`define MDST_CMD_WRITE     30
`define MDST_CMD_ACK       29
`define MDST_SEL_LINK_EN   6
`define MDST_SEL_SRC       7
`define MDST_TOP_CHANNEL   5'h01
`define MDST_RST_DIV       16'h0000
`define MDST_STATUS_REG    5'h01
`define MDST_STATUS_LINK   2
`define MDST_PRE_BITS      6'h20
`define MDST_TA_BIT        6'h2f
`define MDST_DATA_BIT      6'h30
`define MDST_LAST_BIT      6'h3f
`endif

// ### design/mdst_pkg.sv
// Types shared by the management status block
package mdst_pkg;
  typedef enum logic [0:0] {MDST_IDLE, MDST_FRAME} mdst_state_t;
  typedef enum logic [1:0] {MDST_SRC_CH0, MDST_SRC_CH1, MDST_SRC_POLL} mdst_src_t;
endpackage : mdst_pkg

// ### tb/mdst_phy_model.sv
// Behavioural model of the PHYs on the management serial bus
`timescale 1ns/100ps
module mdst_phy_model (
  input  wire logic        mdc,     // Serial clock from the controller
  input  wire logic        mdio_o,  // Controller drive value
  input  wire logic        mdio_oe, // Controller drive enable
  input  wire logic [31:0] present, // Addresses that answer
  input  wire logic [31:0] link_up, // Link state per address
  output logic             phy_oe,  // Model drives the line
  output logic             phy_o    // Model drive value
);
  logic [5:0]  idx;
  logic [15:0] hdr;
  logic [15:0] rdat;
  // Status word carries the link flag in bit 2
  assign rdat = {hdr[9:5], hdr[4:0], 3'b000, link_up[hdr[9:5]], 2'b01};
  initial
  begin
    idx = 6'h00;
    hdr = 16'h0000;
    phy_oe = 1'b0;
    phy_o = 1'b0;
  end
  // ------------------------------------------------------------------
  // Header capture; a driven 0 outside a frame is the start bit
  // ------------------------------------------------------------------
  always @(posedge mdc)
  begin
    if (idx == 6'h00 && mdio_oe && !mdio_o)
      idx <= 6'h01;
    else if (idx != 6'h00)
      idx <= (idx == 6'h1f) ? 6'h00 : idx + 6'h01;
    if (idx < 6'h0e)
      hdr <= {hdr[14:0], mdio_o};
  end
  // Drive after the falling edge so the line is settled at the sample point
  always @(negedge mdc)
  begin
    phy_oe <= hdr[11:10] == 2'b10 && present[hdr[9:5]] && idx >= 6'h0f;
    phy_o  <= (idx == 6'h0f) ? 1'b0 : rdat[~idx[3:0]];
  end
endmodule : mdst_phy_model

// ### tb/mdst_top_tb.sv
// Self-checking bench for the management status block
`timescale 1ns/100ps
`include "mdst_regs.svh"
module mdst_top_tb;
  logic        sys_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, force_low;
  logic [7:0]  wb_adr_i, ca;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, present, link_up, q;
  logic        wb_ack_o, mgmt_serial_clock, mdio_o, mdio_oe, mdio_i, link_irq, user_irq;
  logic        phy_oe, phy_o, w, b0;
  logic [4:0]  pa, ra;
  logic [15:0] dv;
  int          error_cnt, check_count, seed, n, i, run, maxrun;
  logic [7:0]  offs [7] = '{`MDST_OFF_PRESENCE, `MDST_OFF_LINK, `MDST_OFF_LC_RAW,
                            `MDST_OFF_LC_MSK, `MDST_OFF_CD_RAW, `MDST_OFF_CD_MSK,
                            `MDST_OFF_MASK_SET};
  // Pull-up when nobody drives; force_low models a shorted line
  assign mdio_i = force_low ? 1'b0 : mdio_oe ? mdio_o : phy_oe ? phy_o : 1'b1;
  mdst_top u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mgmt_serial_clock(mgmt_serial_clock), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .mdio_i(mdio_i), .link_irq(link_irq), .user_irq(user_irq));
  mdst_phy_model u_phy (.mdc(mgmt_serial_clock), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .present(present), .link_up(link_up), .phy_oe(phy_oe), .phy_o(phy_o));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Longest run of driven ones shows whether a preamble was sent
  always @(posedge mgmt_serial_clock)
  begin
    run = (mdio_oe && mdio_o) ? run + 1 : 0;
    if (run > maxrun) maxrun = run;
  end
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int k;
    k = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do
    begin
      @(posedge sys_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      error_cnt++;
      test_done();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0000_0000, 4'hf);
  endtask : rd
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask : wreg
  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    for (int k = 0; k < 300; k++)
    begin
      rd(a);
      if (q[b] === v) return;
    end
    error_cnt++;
    test_done();
  endtask : wait_bit
  task automatic rises(input int win);
    n = 0;
    b0 = mgmt_serial_clock;
    repeat (win)
    begin
      @(posedge sys_clk);
      n += (mgmt_serial_clock && !b0);
      b0 = mgmt_serial_clock;
    end
  endtask : rises
  function automatic logic [15:0] exp_rd(input logic [4:0] p, input logic [4:0] r);
    return {p, r, 3'b000, link_up[p], 2'b01};
  endfunction : exp_rd
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    seed = 91; force_low = 1'b0; present = 32'h0000_0220; link_up = 32'h0000_0020;
    wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = 8'h00;
    wb_sel_i = 4'hf; wb_dat_i = 32'h0; sys_rst = 1'b1; run = 0; maxrun = 0;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(`MDST_OFF_CONTROL); chk(q, 32'h8100_0000);
    foreach (offs[j]) begin rd(offs[j]); chk(q, 32'h0); end
    wreg(8'h30, 32'hffff_ffff); rd(8'h30); chk(q, 32'h0);
    rises(40); chk(n, 0);
    wreg(`MDST_OFF_SEL0, 32'h0000_00c5); wreg(`MDST_OFF_SEL1, 32'h0000_0009);
    rd(`MDST_OFF_SEL0); chk(q, 32'h0000_0045);
    wreg(`MDST_OFF_CONTROL, 32'h4010_0003);
    rises(40); chk(n, 10);
    maxrun = 0;
    wait_bit(`MDST_OFF_LINK, 5, 1'b1);
    wait_bit(`MDST_OFF_PRESENCE, 9, 1'b1);
    chk(maxrun < 32, 1);
    rd(`MDST_OFF_LC_RAW); chk(q, 32'h1);
    rd(`MDST_OFF_LC_MSK); chk(q, 32'h1);
    chk(link_irq, 1'b1);
    wreg(`MDST_OFF_CONTROL, 32'h0010_0003);
    wait_bit(`MDST_OFF_CONTROL, 31, 1'b1);
    wb(1'b1, `MDST_OFF_PRESENCE, 32'hffff_ffff, 4'h0);
    wreg(`MDST_OFF_PRESENCE, 32'h0000_0200); rd(`MDST_OFF_PRESENCE); chk(q, 32'h20);
    wreg(`MDST_OFF_LINK, 32'hffff_ffff); rd(`MDST_OFF_LINK); chk(q, 32'h20);
    wreg(`MDST_OFF_LC_RAW, 32'h0); rd(`MDST_OFF_LC_RAW); chk(q, 32'h1);
    wreg(`MDST_OFF_LC_RAW, 32'h1); rd(`MDST_OFF_LC_RAW); chk(q, 32'h0);
    wreg(`MDST_OFF_LC_MSK, 32'h1); rd(`MDST_OFF_LC_MSK); chk(q, 32'h0);
    chk(link_irq, 1'b0);
    wreg(`MDST_OFF_CMD0, 32'h8000_0000); rd(`MDST_OFF_CMD0); chk(q[31], 1'b0);
    link_up = 32'h0000_0220;
    wreg(`MDST_OFF_CONTROL, 32'h4010_0003);
    wait_bit(`MDST_OFF_LC_RAW, 1, 1'b1);
    rd(`MDST_OFF_LC_MSK); chk(q, 32'h0);
    wreg(`MDST_OFF_MASK_SET, 32'h1); wreg(`MDST_OFF_MASK_SET, 32'h0);
    rd(`MDST_OFF_MASK_SET); chk(q, 32'h1);
    for (i = 0; i < 6; i++)
    begin
      pa = $random(seed); ra = $random(seed); w = $random(seed); dv = $random(seed);
      present = $random(seed) | 32'h0000_0220;
      ca = i[0] ? `MDST_OFF_CMD1 : `MDST_OFF_CMD0;
      wreg(ca, {1'b1, w, 4'h0, ra, pa, dv});
      wreg(ca, 32'h0000_0000);
      wait_bit(ca, 31, 1'b0);
      chk(q[29], w | present[pa]);
      chk(q[15:0], w ? dv : present[pa] ? exp_rd(pa, ra) : 16'hffff);
      rd(`MDST_OFF_PRESENCE); chk(q[pa], w | present[pa]);
      rd(`MDST_OFF_CD_RAW); chk(q, i[0] ? 32'h2 : 32'h1);
      rd(`MDST_OFF_CD_MSK); chk(q, i[0] ? 32'h0 : 32'h1);
      chk(user_irq, !i[0]);
      wreg(`MDST_OFF_CD_RAW, 32'h3); wreg(`MDST_OFF_CD_MSK, 32'h3);
      rd(`MDST_OFF_CD_RAW); chk(q, 32'h0);
      chk(user_irq, 1'b0);
    end
    wreg(`MDST_OFF_MASK_CLR, 32'h1); rd(`MDST_OFF_MASK_SET); chk(q, 32'h0);
    wreg(`MDST_OFF_CONTROL, 32'h4000_0003);
    force_low <= 1'b1;
    maxrun = 0;
    repeat (600) @(posedge sys_clk);
    chk(maxrun, 32);
    rd(`MDST_OFF_CONTROL); chk(q[19], 1'b0);
    wreg(`MDST_OFF_CONTROL, 32'h4004_0003);
    wait_bit(`MDST_OFF_CONTROL, 19, 1'b1);
    force_low <= 1'b0;
    wreg(`MDST_OFF_CONTROL, 32'h0008_0003);
    rd(`MDST_OFF_CONTROL); chk(q[19], 1'b0);
    // Second reset after traffic: presence bits from the polls must be gone
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(`MDST_OFF_PRESENCE); chk(q, 32'h0);
    rd(`MDST_OFF_CONTROL); chk(q, 32'h8100_0000);
    rises(20); chk(n, 0);
    test_done();
  end
endmodule : mdst_top_tb
